//--- include/irc_pkg.sv
package irc_pkg;
    // ==========================================================
    // clocking and bit timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned BAUD = 9600;
    localparam int unsigned TICKS_PER_BIT = 16;
    localparam int unsigned TICK_DIV = CLK_HZ / (BAUD * TICKS_PER_BIT);
    localparam int unsigned FRAME_BITS = 10;
    localparam int unsigned DEC_BITS = 9;
    localparam int unsigned UART_SAMPLE_PHASE = TICKS_PER_BIT / 2 - 1;
    // ==========================================================
    // pulse shape
    localparam int unsigned ENC_LOW_HEAD = 7;
    localparam int unsigned ENC_HIGH = 3;
    localparam int unsigned ENC_LOW_TAIL = 6;
    localparam int unsigned DEC_LOW_TICKS = 3;
    localparam int unsigned DEC_HIGH_TICKS = 13;
    localparam int unsigned MIN_PULSE_NS = 1600;
    localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ==========================================================
    // buffers and packets
    localparam int unsigned HOST_BUF_MAX = 29;
    localparam int unsigned CTS_LEVEL = 23;
    localparam int unsigned CTS_SLACK = 6;
    localparam int unsigned IR_BLOCK = 64;
    localparam int unsigned HOST_BLOCK = 29;
    localparam int unsigned PROTO_OVERHEAD = 8;
    localparam int unsigned MIN_FRAME = 6;
    // ==========================================================
    // low power and revision code
    localparam longint unsigned IDLE_SEC = 10;
    localparam longint unsigned IDLE_CYCLES = IDLE_SEC * longint'(CLK_HZ);
    localparam logic [7:0] DEV_REV_DEFAULT = 8'h5A;
endpackage

//--- include/irc_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface irc_stream_if #(
    parameter int unsigned WIDTH = 8
);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport sink(input data, input valid, output ready);
    modport source(output data, output valid, input ready);
endinterface
`default_nettype wire

//--- rtl/irc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module irc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    irc_stream_if.sink wr,
    irc_stream_if.source rd,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    // ==========================================================
    // parameter check
    if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(wr.data) != WIDTH) begin : g_bad
        $error("irc_fifo: depth must be a power of two and width must match");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    wire do_wr;
    wire do_rd;

    assign wr.ready = (count_reg != CW'(DEPTH));
    assign rd.valid = (count_reg != '0);
    assign rd.data = mem_reg[rd_ptr_reg];
    assign do_wr = wr.valid && wr.ready;
    assign do_rd = rd.valid && rd.ready;
    assign count = count_reg;

    // ==========================================================
    // storage carries data only, so it needs no reset
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem_reg[wr_ptr_reg] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= do_wr ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= do_rd ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            count_reg <= CW'(count_reg + CW'(do_wr) - CW'(do_rd));
        end
    end
endmodule // irc_fifo
`default_nettype wire

//--- rtl/irc_codec.sv
`timescale 1ns/10ps
`default_nettype none
module irc_codec #(
    parameter int unsigned TICK_DIV = irc_pkg::TICK_DIV,
    parameter longint unsigned IDLE_CYCLES = irc_pkg::IDLE_CYCLES,
    parameter int unsigned HOST_DEPTH = 32,
    parameter int unsigned IR_DEPTH = 64,
    parameter logic [7:0] DEV_REV = irc_pkg::DEV_REV_DEFAULT // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic host_tx_in,
    output logic host_rx_out,
    input wire logic rts_n_in,
    output logic cts_out,
    output logic ir_tx_out,
    input wire logic ir_rx_in,
    input wire logic photo_detect_cross,
    input wire logic link_open,
    output logic handler_active_o,
    output logic handler_active_oe,
    output logic osc_run,
    output logic disconnected_state,
    output logic [15:0] ir_rate_code,
    output logic [7:0] id_rev,
    output logic [7:0] tx_frame_len,
    output logic [6:0] rx_block_fill
);
    localparam int unsigned HCW = $clog2(HOST_DEPTH + 1);
    localparam int unsigned ICW = $clog2(IR_DEPTH + 1);
    localparam logic [3:0] PH_LAST = 4'(irc_pkg::TICKS_PER_BIT - 1);

    // ==========================================================
    // parameter checks
    if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_bad_div
        $error("irc_codec: tick divider out of range");
    end
    if (longint'(TICK_DIV) * irc_pkg::ENC_HIGH < irc_pkg::MIN_PULSE_CYC) begin : g_bad_pulse
        $error("irc_codec: zero-bit pulse shorter than the least pulse width");
    end
    if (HOST_DEPTH < irc_pkg::CTS_LEVEL + irc_pkg::CTS_SLACK || IR_DEPTH < irc_pkg::IR_BLOCK) begin : g_bad_buf
        $error("irc_codec: buffers too small");
    end
    if (IDLE_CYCLES < 2 || IDLE_CYCLES > 64'hFFFF_FFFF) begin : g_bad_idle
        $error("irc_codec: idle count out of range");
    end

    function automatic logic [3:0] phase_inc(input logic [3:0] p);
        phase_inc = 4'(p + 4'd1);
    endfunction

    // ==========================================================
    // declarations
    typedef enum logic [0:0] {IRC_IDLE, IRC_RUN} irc_eng_t;

    logic [15:0] div_reg;
    logic tick_reg;
    logic wake_s1_reg;
    logic wake_s2_reg;
    logic awake_reg;
    logic [31:0] idle_cnt_reg;

    irc_eng_t enc_state_reg;
    logic [3:0] enc_phase_reg;
    logic [3:0] enc_bit_reg;
    logic [9:0] enc_sr_reg;
    logic ir_tx_reg;

    irc_eng_t dec_state_reg;
    logic [3:0] dec_phase_reg;
    logic [3:0] dec_bit_reg;
    logic [8:0] dec_sr_reg;
    logic dec_low_reg;
    logic dec_push_reg;
    logic [4:0] guard_reg;

    irc_eng_t urx_state_reg;
    logic [3:0] urx_phase_reg;
    logic [3:0] urx_bit_reg;
    logic [8:0] urx_sr_reg;
    logic urx_push_reg;

    irc_eng_t utx_state_reg;
    logic [3:0] utx_phase_reg;
    logic [3:0] utx_bit_reg;
    logic [9:0] utx_sr_reg;
    logic host_rx_reg;

    logic cts_reg;
    logic disc_reg;
    logic ha_oe_reg;
    logic osc_reg;
    logic [15:0] rate_reg;
    logic [7:0] rev_reg;
    logic [4:0] tx_blk_reg;
    logic [6:0] rx_blk_reg;
    logic [7:0] frame_len_reg;

    logic [HCW-1:0] host_count;
    logic [ICW-1:0] ir_count;

    irc_stream_if #(.WIDTH(8)) host_wr ();
    irc_stream_if #(.WIDTH(8)) host_rd ();
    irc_stream_if #(.WIDTH(8)) ir_wr ();
    irc_stream_if #(.WIDTH(8)) ir_rd ();

    // ==========================================================
    // decode
    wire div_wrap = (div_reg == 16'(TICK_DIV - 1));
    wire enc_bit_end = tick_reg && (enc_phase_reg == PH_LAST);
    wire dec_bit_end = tick_reg && (dec_phase_reg == PH_LAST);
    wire urx_bit_end = tick_reg && (urx_phase_reg == PH_LAST);
    wire utx_bit_end = tick_reg && (utx_phase_reg == PH_LAST);
    wire enc_pulse = (enc_phase_reg >= 4'(irc_pkg::ENC_LOW_HEAD))
        && (enc_phase_reg < 4'(irc_pkg::ENC_LOW_HEAD + irc_pkg::ENC_HIGH));
    wire enc_start = (enc_state_reg == IRC_IDLE) && host_rd.valid && awake_reg
        && (dec_state_reg == IRC_IDLE) && (guard_reg == '0) && !dec_push_reg && ir_rx_in
        && tick_reg;
    wire dec_start = (dec_state_reg == IRC_IDLE) && (enc_state_reg == IRC_IDLE)
        && awake_reg && !ir_rx_in;
    wire dec_done = dec_bit_end && (dec_bit_reg == 4'(irc_pkg::DEC_BITS - 1));
    wire urx_start = (urx_state_reg == IRC_IDLE) && awake_reg && !host_tx_in;
    wire urx_done = urx_bit_end && (urx_bit_reg == 4'(irc_pkg::DEC_BITS - 1));
    // starting on a tick keeps the first bit a full sixteen ticks long
    wire utx_start = (utx_state_reg == IRC_IDLE) && ir_rd.valid && !rts_n_in && awake_reg
        && tick_reg;
    wire ir_activity = !ir_rx_in || (enc_state_reg == IRC_RUN) || (dec_state_reg == IRC_RUN);
    wire host_room = (host_count < HCW'(irc_pkg::HOST_BUF_MAX));
    wire tx_blk_wrap = (tx_blk_reg == 5'(irc_pkg::HOST_BLOCK - 1));
    wire rx_blk_wrap = (rx_blk_reg == 7'(irc_pkg::IR_BLOCK - 1));

    assign host_rd.ready = enc_start;
    assign ir_rd.ready = utx_start;
    assign ir_wr.valid = dec_push_reg;
    assign ir_wr.data = dec_sr_reg[8:1];
    assign host_wr.valid = urx_push_reg;
    assign host_wr.data = urx_sr_reg[8:1];

    // ==========================================================
    // buffers
    irc_fifo #(.WIDTH(8), .DEPTH(HOST_DEPTH)) u_host_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr(host_wr),
        .rd(host_rd),
        .count(host_count)
    );

    irc_fifo #(.WIDTH(8), .DEPTH(IR_DEPTH)) u_ir_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr(ir_wr),
        .rd(ir_rd),
        .count(ir_count)
    );

    // ==========================================================
    // bit tick, stopped while asleep to stand in for the halted oscillator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= (!awake_reg || div_wrap) ? '0 : 16'(div_reg + 16'd1);
            tick_reg <= awake_reg && div_wrap;
        end
    end

    // ==========================================================
    // low power and wake; the synchroniser runs regardless of awake
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
            awake_reg <= 1'b1;
            idle_cnt_reg <= '0;
        end else begin
            wake_s1_reg <= photo_detect_cross;
            wake_s2_reg <= wake_s1_reg;
            if (!awake_reg) begin
                awake_reg <= wake_s2_reg;
                idle_cnt_reg <= '0;
            end else if (ir_activity || !disc_reg) begin
                idle_cnt_reg <= '0;
            end else if (idle_cnt_reg == 32'(IDLE_CYCLES - 1)) begin
                awake_reg <= 1'b0;
                idle_cnt_reg <= '0;
            end else begin
                idle_cnt_reg <= 32'(idle_cnt_reg + 32'd1);
            end
        end
    end

    // ==========================================================
    // encoder: host bytes to infrared pulses
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enc_state_reg <= IRC_IDLE;
            enc_phase_reg <= '0;
            enc_bit_reg <= '0;
            enc_sr_reg <= '1;
        end else begin
            unique case (enc_state_reg)
                IRC_IDLE: begin
                    if (enc_start) begin
                        enc_state_reg <= IRC_RUN;
                        enc_phase_reg <= '0;
                        enc_bit_reg <= '0;
                        enc_sr_reg <= {1'b1, host_rd.data, 1'b0};
                    end
                end
                IRC_RUN: begin
                    if (tick_reg) begin
                        enc_phase_reg <= phase_inc(enc_phase_reg);
                    end
                    if (enc_bit_end) begin
                        enc_bit_reg <= 4'(enc_bit_reg + 4'd1);
                        enc_sr_reg <= {1'b1, enc_sr_reg[9:1]};
                        if (enc_bit_reg == 4'(irc_pkg::FRAME_BITS - 1)) begin
                            enc_state_reg <= IRC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // zero: low, 3-tick high pulse, low; one: low throughout
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ir_tx_reg <= 1'b0;
        end else begin
            ir_tx_reg <= (enc_state_reg == IRC_RUN) && !enc_sr_reg[0] && enc_pulse;
        end
    end

    // ==========================================================
    // decoder: any low inside a 16-tick window is a zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dec_state_reg <= IRC_IDLE;
            dec_phase_reg <= '0;
            dec_bit_reg <= '0;
            dec_sr_reg <= '1;
            dec_low_reg <= 1'b0;
            dec_push_reg <= 1'b0;
        end else begin
            dec_push_reg <= 1'b0;
            unique case (dec_state_reg)
                IRC_IDLE: begin
                    if (dec_start) begin
                        dec_state_reg <= IRC_RUN;
                        dec_phase_reg <= '0;
                        dec_bit_reg <= '0;
                        dec_low_reg <= 1'b1;
                    end
                end
                IRC_RUN: begin
                    if (tick_reg) begin
                        dec_phase_reg <= phase_inc(dec_phase_reg);
                    end
                    if (dec_bit_end) begin
                        dec_low_reg <= !ir_rx_in;
                        dec_sr_reg <= {!(dec_low_reg || !ir_rx_in), dec_sr_reg[8:1]};
                        dec_bit_reg <= 4'(dec_bit_reg + 4'd1);
                    end else begin
                        dec_low_reg <= dec_low_reg || !ir_rx_in;
                    end
                    if (dec_done) begin
                        // stop bit is not decoded; the byte is whole here
                        dec_state_reg <= IRC_IDLE;
                        dec_push_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // one bit time of quiet after a received byte before transmitting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            guard_reg <= '0;
        end else if (dec_push_reg) begin
            guard_reg <= 5'(irc_pkg::TICKS_PER_BIT);
        end else if (tick_reg && guard_reg != '0) begin
            guard_reg <= 5'(guard_reg - 5'd1);
        end
    end

    // ==========================================================
    // host uart receiver, mid-bit sampling
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            urx_state_reg <= IRC_IDLE;
            urx_phase_reg <= '0;
            urx_bit_reg <= '0;
            urx_sr_reg <= '1;
            urx_push_reg <= 1'b0;
        end else begin
            urx_push_reg <= 1'b0;
            unique case (urx_state_reg)
                IRC_IDLE: begin
                    if (urx_start) begin
                        urx_state_reg <= IRC_RUN;
                        urx_phase_reg <= '0;
                        urx_bit_reg <= '0;
                    end
                end
                IRC_RUN: begin
                    if (tick_reg) begin
                        urx_phase_reg <= phase_inc(urx_phase_reg);
                    end
                    if (tick_reg && urx_phase_reg == 4'(irc_pkg::UART_SAMPLE_PHASE)) begin
                        urx_sr_reg <= {host_tx_in, urx_sr_reg[8:1]};
                    end
                    if (urx_bit_end) begin
                        urx_bit_reg <= 4'(urx_bit_reg + 4'd1);
                    end
                    if (urx_done) begin
                        urx_state_reg <= IRC_IDLE;
                        // bytes past the 29-byte limit are lost; 6 of slack after cts
                        urx_push_reg <= !urx_sr_reg[0] && host_room;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // host uart transmitter, paced by ready-to-send
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            utx_state_reg <= IRC_IDLE;
            utx_phase_reg <= '0;
            utx_bit_reg <= '0;
            utx_sr_reg <= '1;
        end else begin
            unique case (utx_state_reg)
                IRC_IDLE: begin
                    if (utx_start) begin
                        utx_state_reg <= IRC_RUN;
                        utx_phase_reg <= '0;
                        utx_bit_reg <= '0;
                        utx_sr_reg <= {1'b1, ir_rd.data, 1'b0};
                    end
                end
                IRC_RUN: begin
                    if (tick_reg) begin
                        utx_phase_reg <= phase_inc(utx_phase_reg);
                    end
                    if (utx_bit_end) begin
                        utx_bit_reg <= 4'(utx_bit_reg + 4'd1);
                        utx_sr_reg <= {1'b1, utx_sr_reg[9:1]};
                        if (utx_bit_reg == 4'(irc_pkg::FRAME_BITS - 1)) begin
                            utx_state_reg <= IRC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            host_rx_reg <= 1'b1;
        end else begin
            host_rx_reg <= (utx_state_reg == IRC_RUN) ? utx_sr_reg[0] : 1'b1;
        end
    end

    // ==========================================================
    // packet block accounting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_blk_reg <= '0;
            rx_blk_reg <= '0;
        end else begin
            if (disc_reg) begin
                tx_blk_reg <= '0;
            end else if (enc_start) begin
                tx_blk_reg <= tx_blk_wrap ? '0 : 5'(tx_blk_reg + 5'd1);
            end
            if (disc_reg) begin
                rx_blk_reg <= '0;
            end else if (dec_push_reg) begin
                rx_blk_reg <= rx_blk_wrap ? '0 : 7'(rx_blk_reg + 7'd1);
            end
        end
    end

    // ==========================================================
    // status outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cts_reg <= 1'b1;
            disc_reg <= 1'b1;
            ha_oe_reg <= 1'b0;
            osc_reg <= 1'b1;
            rate_reg <= '0;
            rev_reg <= '0;
            frame_len_reg <= 8'(irc_pkg::PROTO_OVERHEAD);
        end else begin
            disc_reg <= !link_open;
            // host is also held off while the link is down
            cts_reg <= (host_count >= HCW'(irc_pkg::CTS_LEVEL)) || disc_reg;
            ha_oe_reg <= !awake_reg;
            osc_reg <= awake_reg;
            rate_reg <= disc_reg ? 16'(irc_pkg::BAUD) : '0;
            rev_reg <= DEV_REV;
            frame_len_reg <= 8'(tx_blk_reg) + 8'(irc_pkg::PROTO_OVERHEAD);
        end
    end

    assign host_rx_out = host_rx_reg;
    assign cts_out = cts_reg;
    assign ir_tx_out = ir_tx_reg;
    assign handler_active_o = 1'b0; // open collector: only ever pulls low
    assign handler_active_oe = ha_oe_reg;
    assign osc_run = osc_reg;
    assign disconnected_state = disc_reg;
    assign ir_rate_code = rate_reg;
    assign id_rev = rev_reg;
    assign tx_frame_len = frame_len_reg;
    assign rx_block_fill = rx_blk_reg;
endmodule // irc_codec
`default_nettype wire

//--- test/irc_codec_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module irc_codec_assertions #(
    parameter int unsigned TICK_DIV = 134,
    parameter logic [7:0] DEV_REV = 8'h5A
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic host_rx_out,
    input wire logic cts_out,
    input wire logic ir_tx_out,
    input wire logic photo_detect_cross,
    input wire logic handler_active_o,
    input wire logic handler_active_oe,
    input wire logic osc_run,
    input wire logic disconnected_state,
    input wire logic [15:0] ir_rate_code,
    input wire logic [7:0] id_rev
);
    // ========
    // run-length helpers, a long repetition would stall the tools
    localparam int MIN_HI = 400;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [31:0] hi_reg;
    logic [31:0] lvl_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hi_reg <= '0;
            lvl_reg <= '0;
        end else begin
            hi_reg <= ir_tx_out ? hi_reg + 1 : '0;
            lvl_reg <= $changed(host_rx_out) ? '0 : lvl_reg + 1;
        end
    end
    property p_pulse; $fell(ir_tx_out) |-> hi_reg == 3 * TICK_DIV; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length wrong");
    property p_min; $fell(ir_tx_out) |-> hi_reg >= MIN_HI; endproperty
    a_min: assert property (p_min) else $error("pulse too short");
    property p_oc; handler_active_o == 1'b0; endproperty
    a_oc: assert property (p_oc) else $error("active pin driven high");
    property p_sleep; !osc_run ##1 !osc_run |-> handler_active_oe; endproperty
    a_sleep: assert property (p_sleep) else $error("asleep but pin released");
    property p_rate; disconnected_state [*2] |-> ir_rate_code == 16'h2580; endproperty
    a_rate: assert property (p_rate) else $error("rate not reported");
    property p_id; $past(rst_n) |-> id_rev == DEV_REV; endproperty
    a_id: assert property (p_id) else $error("revision code wrong");
    property p_lvl; $changed(host_rx_out) |-> lvl_reg >= 16 * TICK_DIV - 1; endproperty
    a_lvl: assert property (p_lvl) else $error("host bit too short");
    property p_wake; $rose(photo_detect_cross) && !osc_run |-> ##[1:4] osc_run; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_cts; disconnected_state [*2] |-> cts_out; endproperty
    a_cts: assert property (p_cts) else $error("cts low while disconnected");
endmodule // irc_codec_assertions
bind irc_codec irc_codec_assertions #(.TICK_DIV(TICK_DIV), .DEV_REV(DEV_REV)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .host_rx_out(host_rx_out), .cts_out(cts_out),
    .ir_tx_out(ir_tx_out), .photo_detect_cross(photo_detect_cross),
    .handler_active_o(handler_active_o), .handler_active_oe(handler_active_oe),
    .osc_run(osc_run), .disconnected_state(disconnected_state),
    .ir_rate_code(ir_rate_code), .id_rev(id_rev));
`default_nettype wire

//--- test/irc_ir_peer.sv
`timescale 1ns/10ps
`default_nettype none
module irc_ir_peer #(
    parameter int unsigned TD = 134
) (
    input wire logic clk_sys,
    output logic ir_rx_in
);
    // ========
    // transceiver output idles high; zero bit is a 3-tick low pulse
    initial ir_rx_in = 1'b1;
    // caller starts this only while the device is not sending
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys);
            ir_rx_in = f[i];
            repeat (3 * TD) @(negedge clk_sys);
            ir_rx_in = 1'b1;
            repeat (13 * TD - 1) @(negedge clk_sys);
        end
    endtask
endmodule // irc_ir_peer
`default_nettype wire

//--- test/infrared_bit_codec_lowpower_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module infrared_bit_codec_lowpower_tb_top;
    // ========
    // bench: one host byte and one infrared byte cross at once
    localparam int unsigned TD = 134;
    logic clk_sys = 1'b0, rst_n = 1'b0, host_tx_in = 1'b1, pd = 1'b0, link_open = 1'b1;
    logic host_rx_out, cts_out, ir_tx_out, ir_rx_in, ha_o, ha_oe, osc_run;
    logic [15:0] rate;
    logic [7:0] id_rev, a, b, flen;
    logic [6:0] fill;
    logic rts_n = 1'b1;
    logic [7:0] exp_ir[$], exp_host[$];
    int failures = 0, checks = 0, n;
    wire ha_pin;
    assign ha_pin = ha_oe ? ha_o : 1'b1;
    always #2 clk_sys = ~clk_sys;
    irc_codec #(.TICK_DIV(TD), .IDLE_CYCLES(2000)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .host_tx_in(host_tx_in), .host_rx_out(host_rx_out), .rts_n_in(rts_n),
        .cts_out(cts_out), .ir_tx_out(ir_tx_out), .ir_rx_in(ir_rx_in),
        .photo_detect_cross(pd), .link_open(link_open), .handler_active_o(ha_o),
        .handler_active_oe(ha_oe), .osc_run(osc_run), .disconnected_state(),
        .ir_rate_code(rate), .id_rev(id_rev), .tx_frame_len(flen), .rx_block_fill(fill));
    irc_ir_peer #(.TD(TD)) peer (.clk_sys(clk_sys), .ir_rx_in(ir_rx_in));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic host_send(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int k = 0; k < 1000 && cts_out; k++) @(negedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            host_tx_in = f[i];
            repeat (16 * TD) @(negedge clk_sys);
        end
    endtask
    always begin : ir_mon
        logic [7:0] d;
        @(posedge ir_tx_out);
        // move to mid-pulse so each sample lands inside the next pulse, not before it
        repeat (TD) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (16 * TD) @(negedge clk_sys);
            d[i] = ~ir_tx_out;
        end
        chk("ir_tx_out", exp_ir.size() ? exp_ir.pop_front() : 8'hXX, d);
    end
    always begin : host_mon
        logic [7:0] d;
        @(negedge host_rx_out);
        repeat (8 * TD) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (16 * TD) @(negedge clk_sys);
            d[i] = host_rx_out;
        end
        chk("host_rx_out", exp_host.size() ? exp_host.pop_front() : 8'hXX, d);
    end
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("id_rev", 16'h005A, {8'h00, id_rev});
        chk("cts_out", 16'h0000, {15'h0000, cts_out});
        a = lfsr(8'h12);
        b = lfsr(a);
        exp_ir.push_back(a);
        exp_host.push_back(b);
        fork
            host_send(a);
            peer.send(b);
        join
        // received byte must wait in the buffer while ready-to-send is high
        chk("host_rx_out", 16'h0001, {15'h0000, host_rx_out});
        rts_n = 1'b0;
        for (n = 0; n < 60000 && (exp_ir.size() || exp_host.size()); n++) @(negedge clk_sys);
        chk("traffic_wait", 16'h0000, {15'h0000, n == 60000});
        chk("tx_frame_len", 16'(1 + irc_pkg::PROTO_OVERHEAD), {8'h00, flen});
        chk("rx_block_fill", 16'h0001, {9'h000, fill});
        link_open = 1'b0;
        for (n = 0; n < 9000 && osc_run !== 1'b0; n++) @(negedge clk_sys);
        chk("ha_pin", 16'h0000, {15'h0000, ha_pin});
        chk("rate", 16'h2580, rate);
        chk("tx_frame_len", 16'(irc_pkg::PROTO_OVERHEAD), {8'h00, flen});
        chk("rx_block_fill", 16'h0000, {9'h000, fill});
        pd = 1'b1;
        for (n = 0; n < 20 && osc_run !== 1'b1; n++) @(negedge clk_sys);
        chk("osc_run", 16'h0001, {15'h0000, osc_run});
        print_verdict();
    end
endmodule // infrared_bit_codec_lowpower_tb_top
`default_nettype wire
